// ===== ccrst_pkg.sv
`default_nettype none
package ccrst_pkg;
    // Off-time field value that disables the driver
    localparam logic [3:0]  OFF_TIME_DISABLE  = 4'h0;
    localparam logic [3:0]  OFF_TIME_DEFAULT  = 4'h0;
    localparam logic [19:0] STEP_COUNT_RESET  = 20'hfffff;
    localparam int          STEP_COUNT_W      = 20;
    // Calibration microstep rate and system clock rate
    localparam int          CAL_STEP_HZ       = 1000;
    localparam int          SYS_CLK_HZ        = 250000000;
    localparam int          CAL_STEP_CYCLES   = SYS_CLK_HZ / CAL_STEP_HZ;
    // External clock divider: 250 MHz / 16 gives 15.625 MHz, inside 10..16 MHz
    localparam int          EXT_CLK_DIV       = 16;
    // Internal oscillator modelled as enable every 20 cycles (12.5 MHz)
    localparam int          OSC_DIV           = 20;
    // APB register offsets of the host controller
    localparam logic [7:0]  REG_CTRL          = 8'h00;
    localparam logic [7:0]  REG_STATUS        = 8'h04;
    localparam logic [7:0]  REG_STEP          = 8'h08;
    localparam int          CTRL_CLK_EN       = 0;
    localparam int          CTRL_DRV_EN       = 1;
    localparam int          CTRL_IO_OFF       = 2;
    localparam int          CTRL_CAL_GO       = 3;
    localparam int          CTRL_OFFT_LSB     = 4;
    localparam int          ST_EXT_SEL        = 0;
    localparam int          ST_CAL_BUSY       = 1;
    localparam int          ST_IO_UV          = 2;
endpackage
`default_nettype wire

// ===== ccrst_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ccrst_if;
    logic       clk_pin;
    logic       step_pin;
    logic       enable_n_pin;
    logic       io_supply_good;
    logic       analog_motor_supply_good;
    logic       regulator_output_supply_good;
    logic [3:0] off_time_field;
    logic [19:0] step_interval_count;
    modport device
    (
        input  clk_pin, step_pin, enable_n_pin, io_supply_good,
        input  analog_motor_supply_good, regulator_output_supply_good, off_time_field,
        output step_interval_count
    );
    modport host
    (
        output clk_pin, step_pin, enable_n_pin, io_supply_good, off_time_field,
        input  analog_motor_supply_good, regulator_output_supply_good, step_interval_count
    );
endinterface
`default_nettype wire

// ===== ccrst_device.sv
// Contract
// - Power-on reset loads all register defaults
// - Any monitored supply low resets registers
// - Host keeps core supply always present
// - After reboot host zeroes off-time, reinitialises; host keeps off-time as written
// - Hardware reset: IO supply low, inputs low; host does not force the clock pin low
// - Clock pin grounded: internal oscillator times all
// - Step interval counts clock ticks between steps
// - Host rescales settings to measured clock; host only reports the count at REG_STEP
// - First rising clock pin edge selects external
// - Stopped external clock stops chopper, no fallback
// - Host disables drivers before removing clock
// - Short detection works without clock when enabled
// - External clock 10 to 16 MHz
`timescale 1ns/1ns
`default_nettype none
module ccrst_device
(
    input  wire logic       clk,
    input  wire logic       rst,
    ccrst_if.device         pins,
    input  wire logic       short_det_en,
    input  wire logic       short_to_gnd,
    output logic            short_fault,
    output logic            ext_clk_selected,
    output logic            core_tick,
    output logic            driver_on,
    output logic [3:0]      off_time_active
);
    typedef struct packed
    {
        logic [2:0]  clk_sy;
        logic [2:0]  step_sy;
        logic [2:0]  uv_sy;
        logic [1:0]  en_sy;
        logic        ext_sel;
        logic        osc_tick;
        logic [4:0]  osc_cnt;
        logic [19:0] step_cnt;
        logic [19:0] step_out;
        logic [3:0]  offt;
        logic        drv;
        logic        tick;
    } ccrst_dev_s;

    ccrst_dev_s st_reg;
    ccrst_dev_s st_next;
    logic       supply_bad;
    logic       ext_rise;
    logic       src_tick;

    // ************************************************
    // Clock selection and timing
    // ************************************************
    always_comb
    begin
        st_next         = st_reg;
        st_next.clk_sy  = {st_reg.clk_sy[1:0], pins.clk_pin};
        st_next.step_sy = {st_reg.step_sy[1:0], pins.step_pin};
        st_next.en_sy   = {st_reg.en_sy[0], pins.enable_n_pin};
        st_next.uv_sy   = {st_reg.uv_sy[1:0], ~(pins.io_supply_good
                          & pins.analog_motor_supply_good & pins.regulator_output_supply_good)};
        ext_rise        = st_reg.clk_sy[1] & ~st_reg.clk_sy[2];
        supply_bad      = st_reg.uv_sy[2];
        if (ext_rise)
        begin
            st_next.ext_sel = 1'b1;
        end
        st_next.osc_tick = 1'b0;
        if (st_reg.osc_cnt == 5'(ccrst_pkg::OSC_DIV - 1))
        begin
            st_next.osc_cnt  = 5'h00;
            st_next.osc_tick = 1'b1;
        end
        else
        begin
            st_next.osc_cnt = st_reg.osc_cnt + 5'h01;
        end
        // Internal ticks are masked once external is chosen; no fallback
        src_tick     = st_reg.ext_sel ? ext_rise : st_reg.osc_tick;
        st_next.tick = src_tick;
        if (src_tick)
        begin
            if (st_reg.step_sy[1] & ~st_reg.step_sy[2])
            begin
                st_next.step_out = st_reg.step_cnt;
                st_next.step_cnt = 20'h00001;
            end
            else if (st_reg.step_cnt != ccrst_pkg::STEP_COUNT_RESET)
            begin
                st_next.step_cnt = st_reg.step_cnt + 20'h00001;
            end
            st_next.offt = pins.off_time_field;
            st_next.drv  = ~st_reg.en_sy[1] && (pins.off_time_field != ccrst_pkg::OFF_TIME_DISABLE);
        end
        if (supply_bad)
        begin
            st_next          = '0;
            // Clock and supply synchronisers keep shifting so that supply recovery is seen
            st_next.clk_sy   = {st_reg.clk_sy[1:0], pins.clk_pin};
            st_next.uv_sy    = {st_reg.uv_sy[1:0], ~(pins.io_supply_good
                               & pins.analog_motor_supply_good & pins.regulator_output_supply_good)};
            st_next.step_cnt = ccrst_pkg::STEP_COUNT_RESET;
            st_next.step_out = ccrst_pkg::STEP_COUNT_RESET;
            st_next.offt     = ccrst_pkg::OFF_TIME_DEFAULT;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg          <= '0;
            st_reg.step_cnt <= ccrst_pkg::STEP_COUNT_RESET;
            st_reg.step_out <= ccrst_pkg::STEP_COUNT_RESET;
            st_reg.offt     <= ccrst_pkg::OFF_TIME_DEFAULT;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Short detection is combinational so it works with no clock edges
    assign short_fault              = short_det_en & short_to_gnd;
    assign ext_clk_selected         = st_reg.ext_sel;
    assign core_tick                = st_reg.tick;
    assign driver_on                = st_reg.drv;
    assign off_time_active          = st_reg.offt;
    assign pins.step_interval_count = st_reg.step_out;
endmodule
`default_nettype wire

// ===== ccrst_host.sv
`timescale 1ns/1ns
`default_nettype none
module ccrst_host
(
    input  wire logic        clk,
    input  wire logic        rst,
    ccrst_if.host            pins,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef struct packed
    {
        logic        clk_en;
        logic        drv_en;
        logic        io_off;
        logic        cal_go;
        logic [3:0]  offt;
        logic [5:0]  clk_div;
        logic        clk_out;
        logic [17:0] cal_cnt;
        logic        step;
        logic [31:0] rdata;
        logic [19:0] meas;
        logic [1:0]  uv_sy;
    } ccrst_host_s;

    ccrst_host_s st_reg;
    ccrst_host_s st_next;
    logic        acc;
    logic        bad;

    // ************************************************
    // APB slave and pin drive
    // ************************************************
    always_comb
    begin
        st_next       = st_reg;
        acc           = psel & penable;
        bad           = (paddr != ccrst_pkg::REG_CTRL) && (paddr != ccrst_pkg::REG_STATUS)
                        && (paddr != ccrst_pkg::REG_STEP);
        st_next.uv_sy = {st_reg.uv_sy[0], ~(pins.analog_motor_supply_good
                        & pins.regulator_output_supply_good)};
        st_next.meas  = pins.step_interval_count;
        if (acc && pwrite && (paddr == ccrst_pkg::REG_CTRL))
        begin
            st_next.clk_en = pwdata[ccrst_pkg::CTRL_CLK_EN];
            st_next.drv_en = pwdata[ccrst_pkg::CTRL_DRV_EN];
            st_next.io_off = pwdata[ccrst_pkg::CTRL_IO_OFF];
            st_next.cal_go = pwdata[ccrst_pkg::CTRL_CAL_GO];
            st_next.offt   = pwdata[ccrst_pkg::CTRL_OFFT_LSB +: 4];
            // Clock may only stop while drivers are disabled
            if (!pwdata[ccrst_pkg::CTRL_CLK_EN] && pwdata[ccrst_pkg::CTRL_DRV_EN])
            begin
                st_next.clk_en = st_reg.clk_en;
            end
        end
        if (st_reg.clk_en)
        begin
            if (st_reg.clk_div == 6'(ccrst_pkg::EXT_CLK_DIV / 2 - 1))
            begin
                st_next.clk_div = 6'h00;
                st_next.clk_out = ~st_reg.clk_out;
            end
            else
            begin
                st_next.clk_div = st_reg.clk_div + 6'h01;
            end
        end
        else
        begin
            st_next.clk_div = 6'h00;
            st_next.clk_out = 1'b0;
        end
        st_next.step = 1'b0;
        if (st_reg.cal_go)
        begin
            if (st_reg.cal_cnt == 18'(ccrst_pkg::CAL_STEP_CYCLES - 1))
            begin
                st_next.cal_cnt = 18'h00000;
                st_next.step    = 1'b1;
            end
            else
            begin
                st_next.cal_cnt = st_reg.cal_cnt + 18'h00001;
            end
        end
        st_next.rdata = 32'h00000000;
        if (psel && !penable && !pwrite)
        begin
            if (paddr == ccrst_pkg::REG_CTRL)
            begin
                st_next.rdata = {24'h000000, st_reg.offt, st_reg.cal_go, st_reg.io_off,
                                 st_reg.drv_en, st_reg.clk_en};
            end
            else if (paddr == ccrst_pkg::REG_STATUS)
            begin
                st_next.rdata = {29'h00000000, st_reg.uv_sy[1], st_reg.cal_go, st_reg.clk_en};
            end
            else if (paddr == ccrst_pkg::REG_STEP)
            begin
                st_next.rdata = {12'h000, st_reg.meas};
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata  = st_reg.rdata;
    assign pready  = 1'b1;
    assign pslverr = acc & bad;
    assign pins.clk_pin        = st_reg.clk_out;
    // Hardware reset: IO supply off with step, enable and off-time held low; clock pin not gated
    assign pins.io_supply_good = ~st_reg.io_off;
    assign pins.step_pin       = st_reg.step & ~st_reg.io_off;
    assign pins.enable_n_pin   = ~st_reg.drv_en & ~st_reg.io_off;
    // Off-time field is forced to zero only while IO supply is off; otherwise the off-time as written is driven
    assign pins.off_time_field = st_reg.io_off ? ccrst_pkg::OFF_TIME_DISABLE : st_reg.offt;
endmodule
`default_nettype wire

// ===== ccrst_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ccrst_assertions
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clk_pin,
    input wire logic        step_pin,
    input wire logic        io_supply_good,
    input wire logic        analog_motor_supply_good,
    input wire logic        regulator_output_supply_good,
    input wire logic [19:0] step_interval_count,
    input wire logic        short_det_en,
    input wire logic        short_to_gnd,
    input wire logic        short_fault,
    input wire logic        ext_clk_selected,
    input wire logic        core_tick
);
    logic [7:0] quiet_cnt;
    logic [7:0] step_quiet;
    logic [7:0] gap_cnt;
    logic       pin_q;
    logic       step_q;
    logic       seen;
    wire        bad = !(io_supply_good && analog_motor_supply_good && regulator_output_supply_good);

    // Cycles since clock pin or step pin moved, and since the last tick
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {quiet_cnt, step_quiet, gap_cnt, pin_q, step_q, seen} <= '0;
        end
        else
        begin
            pin_q      <= clk_pin;
            step_q     <= step_pin;
            quiet_cnt  <= (clk_pin != pin_q) ? 8'h00 : quiet_cnt + 8'(quiet_cnt != 8'hff);
            step_quiet <= (step_pin != step_q) ? 8'h00 : step_quiet + 8'(step_quiet != 8'hff);
            gap_cnt    <= core_tick ? 8'h00 : gap_cnt + 8'(gap_cnt != 8'hff);
            seen       <= bad ? 1'b0 : (seen | core_tick);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_supply_reset: assert property (bad [*8] |-> !ext_clk_selected &&
        step_interval_count == ccrst_pkg::STEP_COUNT_RESET) else $error("supply loss kept state");
    a_ext_select: assert property ($rose(clk_pin) && !bad |-> ##[1:6] ext_clk_selected)
        else $error("clock pin edge not taken");
    a_select_held: assert property (ext_clk_selected && !bad |=> ext_clk_selected)
        else $error("clock selection dropped");
    a_no_fallback: assert property (ext_clk_selected && quiet_cnt >= 8'd8 |-> !core_tick)
        else $error("tick without clock pin");
    a_stay_internal: assert property (!ext_clk_selected && quiet_cnt >= 8'd8 |=> !ext_clk_selected)
        else $error("switched without edge");
    a_int_period: assert property (core_tick && !ext_clk_selected && seen && quiet_cnt >= 8'd24
        |-> gap_cnt == 8'(ccrst_pkg::OSC_DIV - 1)) else $error("internal tick period wrong");
    a_short_path: assert property (short_fault == (short_det_en && short_to_gnd))
        else $error("short fault mismatch");
    a_step_measure: assert property ($changed(step_interval_count) &&
        step_interval_count != ccrst_pkg::STEP_COUNT_RESET |-> step_quiet < 8'd6)
        else $error("count moved without step");

    c_ext: cover property ($rose(ext_clk_selected));
    c_supply: cover property (bad [*8]);
    c_tick: cover property (core_tick && !ext_clk_selected);
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        short_det_en;
    logic        short_to_gnd;
    logic        short_fault;
    logic        ext_sel;
    logic        core_tick;
    logic        driver_on;
    logic [3:0]  off_time;
    logic [31:0] rd;
    logic        err_seen;
    int          errors;
    int          check_count;
    int          cycles;
    int          ticks;
    ccrst_if     bus ();

    ccrst_device u_ccrst_device (.clk(clk), .rst(rst), .pins(bus), .short_det_en(short_det_en),
        .short_to_gnd(short_to_gnd), .short_fault(short_fault), .ext_clk_selected(ext_sel),
        .core_tick(core_tick), .driver_on(driver_on), .off_time_active(off_time));
    ccrst_host u_ccrst_host (.clk(clk), .rst(rst), .pins(bus), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    ccrst_assertions u_ccrst_assertions (.clk(clk), .rst(rst), .clk_pin(bus.clk_pin),
        .step_pin(bus.step_pin), .io_supply_good(bus.io_supply_good),
        .analog_motor_supply_good(bus.analog_motor_supply_good),
        .regulator_output_supply_good(bus.regulator_output_supply_good),
        .step_interval_count(bus.step_interval_count), .short_det_en(short_det_en),
        .short_to_gnd(short_to_gnd), .short_fault(short_fault), .ext_clk_selected(ext_sel),
        .core_tick(core_tick));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer followed by an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic close_out;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (core_tick === 1'b1)
            ticks++;
        if (cycles == 20000)
        begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            close_out();
        end
    end

    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata, short_det_en, short_to_gnd} = {1'b1, 45'h0};
        // Motor and regulator supplies start good; scenarios k=0 and k=1 each remove one
        bus.analog_motor_supply_good = 1'b1;
        bus.regulator_output_supply_good = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, ccrst_pkg::REG_STEP, 32'h0);
        check({12'h000, rd[19:0]}, {12'h000, ccrst_pkg::STEP_COUNT_RESET}, "step reset");
        apb(1'b0, ccrst_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h0, "status reset");
        check(32'(ext_sel), 32'h0, "reset selection");
        apb(1'b0, 8'h0c, 32'h0);
        check(32'(err_seen), 32'h1, "unmapped access");
        for (int i = 0; i < 4; i++)
        begin
            short_det_en <= i[0];
            short_to_gnd <= i[1];
            @(posedge clk);
            check(32'(short_fault), 32'(i == 3), "short detect");
        end
        @(negedge clk);
        ticks = 0;
        repeat (100) @(posedge clk);
        @(negedge clk);
        check(32'(ticks), 32'h5, "internal ticks");
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, ccrst_pkg::REG_CTRL, 32'h53);
            for (int n = 0; n < 100 && ext_sel !== 1'b1; n++) @(posedge clk);
            check(32'(ext_sel), 32'h1, "external selected");
            repeat (40) @(posedge clk);
            check(32'(driver_on), 32'h1, "driver enabled");
            check(32'(off_time), 32'h5, "off time taken");
            apb(1'b1, ccrst_pkg::REG_CTRL, 32'h01);
            repeat (40) @(posedge clk);
            check(32'(driver_on), 32'h0, "driver disabled");
            apb(1'b1, ccrst_pkg::REG_CTRL, 32'h00);
            repeat (10) @(posedge clk);
            @(negedge clk);
            ticks = 0;
            repeat (50) @(posedge clk);
            @(negedge clk);
            check(32'(ticks), 32'h0, "ticks after clock stop");
            check(32'(ext_sel), 32'h1, "selection held");
            if (k == 0)
                bus.analog_motor_supply_good <= 1'b0;
            else if (k == 1)
                bus.regulator_output_supply_good <= 1'b0;
            else
                apb(1'b1, ccrst_pkg::REG_CTRL, 32'h04);
            repeat (20) @(posedge clk);
            bus.analog_motor_supply_good <= 1'b1;
            bus.regulator_output_supply_good <= 1'b1;
            if (k == 2)
                apb(1'b1, ccrst_pkg::REG_CTRL, 32'h00);
            repeat (10) @(posedge clk);
            check(32'(ext_sel), 32'h0, "supply reset selection");
            apb(1'b0, ccrst_pkg::REG_STEP, 32'h0);
            check({12'h000, rd[19:0]}, {12'h000, ccrst_pkg::STEP_COUNT_RESET}, "supply step");
        end
        close_out();
    end
endmodule
`default_nettype wire
